// [hw/lcc_regs.svh]
`ifndef LCC_REGS_SVH
`define LCC_REGS_SVH

// Cluster geometry
`define LCC_NUM_CELLS 10
`define LCC_CELL_W 4
`define LCC_LUT_IN 4
`define LCC_LUT_BITS 16
`define LCC_HALF_LUT 8

// Control sources
`define LCC_NUM_LOCAL 4
`define LCC_NUM_GLOBAL 4
`define LCC_NUM_DCLK 2
`define LCC_IDX_W 2

// Cluster-wide control slots
`define LCC_NUM_CTL 8
`define LCC_MAX_CTL 6
`define LCC_CNT_W 4
`define LCC_CTL_CLK_ONE 0
`define LCC_CTL_CLK_TWO 1
`define LCC_CTL_ENA_ONE 2
`define LCC_CTL_ENA_TWO 3
`define LCC_CTL_ACLR_ONE 4
`define LCC_CTL_ACLR_TWO 5
`define LCC_CTL_SCLR 6
`define LCC_CTL_SLOAD 7

`endif

// [hw/lcc_pkg.sv]
package lcc_pkg;
  `include "lcc_regs.svh"

  typedef enum logic [1:0] {LCC_NORMAL, LCC_ARITH, LCC_COUNTER} lcc_mode_t;
  typedef enum logic [1:0] {LCC_FF_D, LCC_FF_T, LCC_FF_JK, LCC_FF_SR} lcc_ff_t;
  typedef enum logic [1:0] {LCC_SRC_OFF, LCC_SRC_LOCAL, LCC_SRC_GLOBAL, LCC_SRC_DCLK} lcc_src_t;
  typedef enum logic [1:0] {LCC_AC_CLEAR, LCC_AC_PRESET, LCC_AC_LOAD} lcc_aclr_t;

  typedef struct packed {
    logic [`LCC_NUM_CELLS-1:0] q;
    logic [`LCC_NUM_CELLS-1:0] out_a;
    logic [`LCC_NUM_CELLS-1:0] out_b;
    logic [1:0] clk_prev;
    logic [`LCC_CNT_W-1:0] ctl_count;
    logic over_limit;
  } lcc_state_t;
endpackage

// [hw/lcc_ctrl.sv]
`timescale 1ns/1ps
module lcc_ctrl
  import lcc_pkg::*;
(
  // Source selection per control slot
  input lcc_src_t [`LCC_NUM_CTL-1:0] ctl_src,
  input logic [`LCC_NUM_CTL-1:0][`LCC_IDX_W-1:0] ctl_idx,
  // Candidate sources
  input logic [`LCC_NUM_LOCAL-1:0] local_ctl,
  input logic [`LCC_NUM_GLOBAL-1:0] global_sig,
  input logic [`LCC_NUM_DCLK-1:0] ded_clk,
  // Resolved control lines
  output logic [`LCC_NUM_CTL-1:0] ctl_line,
  output logic [`LCC_CNT_W-1:0] ctl_count
);

  genvar g;
  generate
    for (g = 0; g < `LCC_NUM_CTL; g++)
    begin : g_slot
      logic idle_val;
      logic dclk_ok;
      // Idle enables read as active so an unused slot never freezes a cell
      assign idle_val = (g == `LCC_CTL_ENA_ONE) || (g == `LCC_CTL_ENA_TWO);
      // Sync clear cannot come from the dedicated clock pins
      assign dclk_ok = (g != `LCC_CTL_SCLR);
      always_comb
      begin
        case (ctl_src[g])
          LCC_SRC_LOCAL: ctl_line[g] = local_ctl[ctl_idx[g]];
          LCC_SRC_GLOBAL: ctl_line[g] = global_sig[ctl_idx[g]];
          LCC_SRC_DCLK: ctl_line[g] = dclk_ok ? ded_clk[ctl_idx[g][0]] : idle_val;
          default: ctl_line[g] = idle_val;
        endcase
      end
    end
  endgenerate

  always_comb
  begin
    ctl_count = 4'h0;
    for (int k = 0; k < `LCC_NUM_CTL; k++)
    begin
      if (ctl_src[k] != LCC_SRC_OFF)
      begin
        ctl_count = ctl_count + 4'h1;
      end
    end
  end

endmodule

// [hw/lcc_cell.sv]
`timescale 1ns/1ps
module lcc_cell
  import lcc_pkg::*;
(
  // Cell configuration
  input lcc_mode_t mode,
  input logic [`LCC_LUT_BITS-1:0] lut_mask,
  input logic carry_as_d3,
  input logic casc_en,
  input logic casc_or,
  // Data and feedback
  input logic [`LCC_LUT_IN-1:0] data,
  input logic q,
  // Chains
  input logic carry_in,
  input logic cascade_in,
  output logic carry_out,
  output logic cascade_out,
  // Combined function result
  output logic func_out
);

  logic [3:0] idx4;
  logic [2:0] idx3;
  logic lut_res;

  always_comb
  begin
    idx4 = {carry_as_d3 ? carry_in : data[3], data[2], data[1], data[0]};
    idx3 = 3'h0;
    lut_res = 1'b0;
    carry_out = carry_in;
    case (mode)
      LCC_ARITH:
      begin
        // Sum and carry from two 3-input halves; pass-through LUT ends an adder
        idx3 = {carry_in, data[1], data[0]};
        lut_res = lut_mask[idx3];
        carry_out = lut_mask[`LCC_HALF_LUT + idx3];
      end
      LCC_COUNTER:
      begin
        // Counter enable on data0, register feedback closes the loop
        idx3 = {carry_in, data[0], q};
        lut_res = lut_mask[idx3];
        carry_out = lut_mask[`LCC_HALF_LUT + idx3];
      end
      default:
      begin
        lut_res = lut_mask[idx4];
      end
    endcase
    if (!casc_en)
    begin
      cascade_out = lut_res;
    end
    else if (casc_or)
    begin
      cascade_out = ~(~lut_res & ~cascade_in);
    end
    else
    begin
      cascade_out = lut_res & cascade_in;
    end
    func_out = cascade_out;
  end

endmodule

// [hw/lcc_cluster.sv]
`timescale 1ns/1ps
module lcc_cluster
  import lcc_pkg::*;
(
  // Clock and reset
  input logic clk_sys,
  input logic reset,
  // Device-wide reset
  input logic device_wide_reset_n,
  input logic dev_reset_enable,
  // Control sources
  input logic [`LCC_NUM_LOCAL-1:0] local_ctl,
  input logic [`LCC_NUM_GLOBAL-1:0] global_sig,
  input logic [`LCC_NUM_DCLK-1:0] ded_clk,
  // Control slot selection
  input lcc_src_t [`LCC_NUM_CTL-1:0] ctl_src,
  input logic [`LCC_NUM_CTL-1:0][`LCC_IDX_W-1:0] ctl_idx,
  input logic [1:0] clk_line_fall,
  // Per-cell configuration
  input lcc_mode_t [`LCC_NUM_CELLS-1:0] cell_mode,
  input logic [`LCC_NUM_CELLS-1:0][`LCC_LUT_BITS-1:0] cell_lut_mask,
  input logic [`LCC_NUM_CELLS-1:0] cell_carry_as_d3,
  input logic [`LCC_NUM_CELLS-1:0] cell_casc_en,
  input logic [`LCC_NUM_CELLS-1:0] cell_casc_or,
  input lcc_ff_t [`LCC_NUM_CELLS-1:0] cell_ff_type,
  input logic [`LCC_NUM_CELLS-1:0] cell_reg_en,
  input logic [`LCC_NUM_CELLS-1:0] cell_clk_line,
  input logic [`LCC_NUM_CELLS-1:0] cell_aclr_en,
  input logic [`LCC_NUM_CELLS-1:0] cell_aclr_line,
  input lcc_aclr_t [`LCC_NUM_CELLS-1:0] cell_aclr_func,
  input logic [`LCC_NUM_CELLS-1:0] cell_sync_en,
  input logic [`LCC_NUM_CELLS-1:0] cell_out_a_reg,
  input logic [`LCC_NUM_CELLS-1:0] cell_out_b_reg,
  // Per-cell data
  input logic [`LCC_NUM_CELLS-1:0][`LCC_CELL_W-1:0] cell_data,
  // Chains from the cluster two places below
  input logic carry_chain_in,
  input logic cascade_chain_in,
  // Chains to the cluster two places above
  output logic carry_chain_out,
  output logic cascade_chain_out,
  // Cell outputs
  output logic [`LCC_NUM_CELLS-1:0] cell_out_a,
  output logic [`LCC_NUM_CELLS-1:0] cell_out_b,
  output logic [`LCC_NUM_CELLS-1:0] cell_q,
  // Status
  output logic [`LCC_CNT_W-1:0] ctl_in_use,
  output logic ctl_over_limit
);

  lcc_state_t s_r;
  lcc_state_t s_nxt;

  logic [`LCC_NUM_CTL-1:0] ctl_line;
  logic [`LCC_CNT_W-1:0] ctl_count;
  logic [1:0] clk_lvl;
  logic [1:0] ena_lvl;
  logic [1:0] aclr_lvl;
  logic [1:0] tick;
  logic sclr;
  logic sload;
  logic dev_rst;
  logic [`LCC_NUM_CELLS:0] carry;
  logic [`LCC_NUM_CELLS:0] casc;
  logic [`LCC_NUM_CELLS-1:0] func;
  logic [`LCC_NUM_CELLS-1:0] q_d;
  logic [`LCC_NUM_CELLS-1:0] out_a_d;
  logic [`LCC_NUM_CELLS-1:0] out_b_d;

  lcc_ctrl u_ctrl (
    .ctl_src(ctl_src),
    .ctl_idx(ctl_idx),
    .local_ctl(local_ctl),
    .global_sig(global_sig),
    .ded_clk(ded_clk),
    .ctl_line(ctl_line),
    .ctl_count(ctl_count)
  );

  // Shared control lines, one copy for all ten cells
  assign clk_lvl = {ctl_line[`LCC_CTL_CLK_TWO], ctl_line[`LCC_CTL_CLK_ONE]};
  assign ena_lvl = {ctl_line[`LCC_CTL_ENA_TWO], ctl_line[`LCC_CTL_ENA_ONE]};
  assign aclr_lvl = {ctl_line[`LCC_CTL_ACLR_TWO], ctl_line[`LCC_CTL_ACLR_ONE]};
  assign sclr = ctl_line[`LCC_CTL_SCLR];
  assign sload = ctl_line[`LCC_CTL_SLOAD];
  assign dev_rst = dev_reset_enable && !device_wide_reset_n;

  // Cluster clocks are sampled levels; each line owns one edge polarity,
  // so a clock used on both edges must be routed to both lines
  genvar l;
  generate
    for (l = 0; l < 2; l++)
    begin : g_line
      assign tick[l] = clk_line_fall[l] ? (s_r.clk_prev[l] && !clk_lvl[l])
                                        : (!s_r.clk_prev[l] && clk_lvl[l]);
    end
  endgenerate

  // Chains enter cell one and leave after cell ten
  assign carry[0] = carry_chain_in;
  assign casc[0] = cascade_chain_in;
  assign carry_chain_out = carry[`LCC_NUM_CELLS];
  assign cascade_chain_out = casc[`LCC_NUM_CELLS];

  genvar i;
  generate
    for (i = 0; i < `LCC_NUM_CELLS; i++)
    begin : g_cell
      logic q;
      logic k_in;
      logic ld_in;
      logic ff_val;
      logic sync_val;
      logic fire;
      logic aclr_hit;
      logic aclr_val;
      logic rst_val;

      assign q = s_r.q[i];
      assign k_in = cell_data[i][3];
      assign ld_in = cell_data[i][2];

      lcc_cell u_cell (
        .mode(cell_mode[i]),
        .lut_mask(cell_lut_mask[i]),
        .carry_as_d3(cell_carry_as_d3[i]),
        .casc_en(cell_casc_en[i]),
        .casc_or(cell_casc_or[i]),
        .data(cell_data[i]),
        .q(q),
        .carry_in(carry[i]),
        .cascade_in(casc[i]),
        .carry_out(carry[i+1]),
        .cascade_out(casc[i+1]),
        .func_out(func[i])
      );

      always_comb
      begin
        // Counter data comes straight from the LUT halves
        if (cell_mode[i] == LCC_COUNTER)
        begin
          ff_val = func[i];
        end
        else
        begin
          case (cell_ff_type[i])
            LCC_FF_T: ff_val = q ^ func[i];
            LCC_FF_JK: ff_val = (func[i] && !q) || (!k_in && q);
            LCC_FF_SR: ff_val = func[i] || (q && !k_in);
            default: ff_val = func[i];
          endcase
        end
      end

      // Clear ahead of load, both ahead of any cascade value
      always_comb
      begin
        if (cell_sync_en[i] && sclr)
        begin
          sync_val = 1'b0;
        end
        else if (cell_sync_en[i] && sload)
        begin
          sync_val = ld_in;
        end
        else
        begin
          sync_val = ff_val;
        end
      end

      // Enable follows whichever clock line the cell picked
      assign fire = cell_reg_en[i] && tick[cell_clk_line[i]] && ena_lvl[cell_clk_line[i]];

      // Clear lines double as async preset and async load
      assign aclr_hit = cell_aclr_en[i] && aclr_lvl[cell_aclr_line[i]];
      always_comb
      begin
        case (cell_aclr_func[i])
          LCC_AC_PRESET: aclr_val = 1'b1;
          LCC_AC_LOAD: aclr_val = ld_in;
          default: aclr_val = 1'b0;
        endcase
      end

      // On device reset, registers with aclr enabled as preset land high, a side effect of the inversion trick
      assign rst_val = cell_aclr_en[i] && (cell_aclr_func[i] == LCC_AC_PRESET);

      always_comb
      begin
        if (dev_rst)
        begin
          q_d[i] = rst_val;
        end
        else if (aclr_hit)
        begin
          q_d[i] = aclr_val;
        end
        else if (fire)
        begin
          q_d[i] = sync_val;
        end
        else
        begin
          q_d[i] = q;
        end
      end

      // Each output picks the function or the register on its own
      assign out_a_d[i] = cell_out_a_reg[i] ? q_d[i] : func[i];
      assign out_b_d[i] = cell_out_b_reg[i] ? q_d[i] : func[i];
    end
  endgenerate

  always_comb
  begin
    s_nxt = s_r;
    s_nxt.q = q_d;
    s_nxt.out_a = out_a_d;
    s_nxt.out_b = out_b_d;
    s_nxt.clk_prev = clk_lvl;
    s_nxt.ctl_count = ctl_count;
    // Over-subscription is only flagged; logic still runs as configured
    s_nxt.over_limit = (ctl_count > 4'(`LCC_MAX_CTL));
  end

  always_ff @(posedge clk_sys)
  begin
    if (reset)
    begin
      s_r <= '0;
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  assign cell_out_a = s_r.out_a;
  assign cell_out_b = s_r.out_b;
  assign cell_q = s_r.q;
  assign ctl_in_use = s_r.ctl_count;
  assign ctl_over_limit = s_r.over_limit;

endmodule

// [verif/lcc_assertions.sv]
`timescale 1ns/1ps
module lcc_assertions
  import lcc_pkg::*;
(
  // Clock and reset
  input logic clk_sys,
  input logic reset,
  // Watched inputs
  input logic device_wide_reset_n,
  input logic dev_reset_enable,
  input lcc_src_t [`LCC_NUM_CTL-1:0] ctl_src,
  input lcc_mode_t [`LCC_NUM_CELLS-1:0] cell_mode,
  input logic [`LCC_NUM_CELLS-1:0] cell_casc_en,
  input logic [`LCC_NUM_CELLS-1:0] cell_casc_or,
  input logic [`LCC_NUM_CELLS-1:0] cell_reg_en,
  input logic [`LCC_NUM_CELLS-1:0] cell_aclr_en,
  input lcc_aclr_t [`LCC_NUM_CELLS-1:0] cell_aclr_func,
  input logic [`LCC_NUM_CELLS-1:0] cell_out_a_reg,
  input logic carry_chain_in,
  input logic cascade_chain_in,
  // Watched outputs
  input logic carry_chain_out,
  input logic cascade_chain_out,
  input logic [`LCC_NUM_CELLS-1:0] cell_out_a,
  input logic [`LCC_NUM_CELLS-1:0] cell_q,
  input logic [`LCC_CNT_W-1:0] ctl_in_use,
  input logic ctl_over_limit
);
  logic [3:0] used;
  logic [9:0] pm;
  logic dv;
  assign dv = dev_reset_enable & ~device_wide_reset_n;
  always_comb
  begin
    used = '0;
    for (int i = 0; i < 8; i++)
      used = used + 4'(ctl_src[i] != LCC_SRC_OFF);
    for (int i = 0; i < 10; i++)
      pm[i] = cell_aclr_en[i] && cell_aclr_func[i] == LCC_AC_PRESET;
  end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (reset);
  property p_lim; ctl_over_limit == (ctl_in_use > 4'h6); endproperty
  a_lim: assert property (p_lim) else $error("limit flag wrong");
  property p_use; !$past(reset) |-> ctl_in_use == $past(used); endproperty
  a_use: assert property (p_use) else $error("control count wrong");
  property p_dev; !$past(reset) && $past(dv) |-> cell_q == $past(pm); endproperty
  a_dev: assert property (p_dev) else $error("device reset wrong");
  property p_pack;
    !$past(reset) |-> ((cell_out_a ^ cell_q) & $past(cell_out_a_reg)) == '0;
  endproperty
  a_pack: assert property (p_pack) else $error("packed output wrong");
  property p_hold;
    !$past(reset) && !$past(dv)
      |-> ((cell_q ^ $past(cell_q)) & $past(~cell_reg_en & ~cell_aclr_en)) == '0;
  endproperty
  a_hold: assert property (p_hold) else $error("bypassed register moved");
  property p_carry; cell_mode == '0 |-> carry_chain_out == carry_chain_in; endproperty
  a_carry: assert property (p_carry) else $error("carry not passed");
  property p_and;
    &cell_casc_en && cell_casc_or == '0 && !cascade_chain_in |-> !cascade_chain_out;
  endproperty
  a_and: assert property (p_and) else $error("cascade and wrong");
  property p_or;
    &cell_casc_en && &cell_casc_or && cascade_chain_in |-> cascade_chain_out;
  endproperty
  a_or: assert property (p_or) else $error("cascade or wrong");
  c_lim: cover property (ctl_over_limit);
  c_dev: cover property (dv);
  c_carry: cover property (carry_chain_out);
endmodule

bind lcc_cluster lcc_assertions i_lcc_assertions(.clk_sys, .reset, .device_wide_reset_n,
  .dev_reset_enable, .ctl_src, .cell_mode, .cell_casc_en, .cell_casc_or, .cell_reg_en,
  .cell_aclr_en, .cell_aclr_func, .cell_out_a_reg, .carry_chain_in, .cascade_chain_in,
  .carry_chain_out, .cascade_chain_out, .cell_out_a, .cell_q, .ctl_in_use, .ctl_over_limit);

// [verif/lcc_nbr.sv]
`timescale 1ns/1ps
// Last cell of the cluster two places below
module lcc_nbr
(
  // Values of that cell
  input logic carry_src,
  input logic casc_src,
  // Chains into our cluster
  output logic carry_chain_in,
  output logic cascade_chain_in
);
  assign carry_chain_in = carry_src;
  assign cascade_chain_in = casc_src;
endmodule

// [verif/tb.sv]
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin bad_count++; \
  $display("mismatch t=%0t got=%h exp=%h", $time, g, e); end end
module tb
  import lcc_pkg::*;
;
  logic clk_sys = 0, reset = 1, device_wide_reset_n = 1, dev_reset_enable = 0;
  logic [3:0] local_ctl = '0, global_sig = '0, ctl_in_use;
  logic [1:0] ded_clk = '0, clk_line_fall = '0;
  typedef lcc_src_t [7:0] src_arr_t;
  src_arr_t ctl_src = src_arr_t'(16'h0000);
  logic [7:0][1:0] ctl_idx = '0;
  lcc_mode_t [9:0] cell_mode = '0;
  logic [9:0][15:0] cell_lut_mask = '0;
  lcc_ff_t [9:0] cell_ff_type = '0;
  lcc_aclr_t [9:0] cell_aclr_func = '0;
  logic [9:0][3:0] cell_data = '0;
  logic [9:0] cell_carry_as_d3 = '0, cell_casc_en = '0, cell_casc_or = '0, cell_reg_en = '0;
  logic [9:0] cell_clk_line = '0, cell_aclr_en = '0, cell_aclr_line = '0, cell_sync_en = '0;
  logic [9:0] cell_out_a_reg = '0, cell_out_b_reg = '0, cell_out_a, cell_out_b, cell_q, e;
  logic carry_src = 0, casc_src = 0, carry_chain_in, cascade_chain_in;
  logic carry_chain_out, cascade_chain_out, ctl_over_limit, c;
  logic [10:0] s;
  logic [9:0] a, b;
  logic [3:0] n;
  logic [31:0] seed = 32'h17ec0;
  int bad_count = 0, checks_done = 0;

  lcc_cluster i_lcc_cluster(.*);
  lcc_nbr i_lcc_nbr(.*);

  always #12.5 clk_sys = ~clk_sys;

  function automatic logic [31:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed;
  endfunction
  function automatic logic [9:0] lut_out();
    for (int i = 0; i < 10; i++)
      lut_out[i] = cell_lut_mask[i][cell_data[i]];
  endfunction
  task automatic tick();
    @(posedge clk_sys);
    #1;
  endtask
  // Cluster clock one: low for a cycle, then high
  task automatic pulse();
    local_ctl[0] = 0;
    tick();
    local_ctl[0] = 1;
    tick();
  endtask
  task automatic complete_run();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  initial
  begin
    #(4000 * 25);
    bad_count++;
    complete_run();
  end

  initial
  begin
    repeat (4) tick();
    reset = 0;
    tick();
    for (int k = 0; k < 20; k++)
    begin
      cell_lut_mask = {rnd(), rnd(), rnd(), rnd(), rnd()};
      cell_data = {rnd(), rnd()};
      e = lut_out();
      tick();
      `CHK(cell_out_a, e)
      `CHK(cell_out_b, e)
    end
    $display("test lut done");
    for (int k = 0; k < 30; k++)
    begin
      ctl_src = src_arr_t'(k ? rnd() : 32'h0000ffff);
      ctl_idx = rnd();
      global_sig = rnd();
      n = 0;
      for (int i = 0; i < 8; i++)
        n = n + 4'(ctl_src[i] != LCC_SRC_OFF);
      tick();
      `CHK(ctl_in_use, n)
      `CHK(ctl_over_limit, n > 4'h6)
    end
    ctl_src = src_arr_t'(16'h0000);
    ctl_idx = '0;
    $display("test count done");
    cell_mode = {10{LCC_ARITH}};
    cell_lut_mask = {10{16'he896}};
    for (int k = 0; k < 20; k++)
    begin
      {a, b, c} = k ? rnd() : {10'h3ff, 10'h000, 1'b1};
      for (int i = 0; i < 10; i++)
        cell_data[i] = {2'b00, b[i], a[i]};
      carry_src = c;
      s = a + b + c;
      tick();
      `CHK(cell_out_a, s[9:0])
      `CHK(carry_chain_out, s[10])
    end
    $display("test adder done");
    cell_mode = '0;
    cell_casc_en = '1;
    for (int o = 0; o < 2; o++)
      for (int k = 0; k < 10; k++)
      begin
        cell_casc_or = {10{o[0]}};
        cell_lut_mask = k ? {rnd(), rnd(), rnd(), rnd(), rnd()} : (o ? '0 : '1);
        cell_data = {rnd(), rnd()};
        casc_src = rnd();
        c = casc_src;
        e = lut_out();
        for (int i = 0; i < 10; i++)
          c = o ? (c | e[i]) : (c & e[i]);
        tick();
        `CHK(cascade_chain_out, c)
      end
    cell_casc_en = '0;
    $display("test cascade done");
    cell_reg_en = '1;
    cell_out_a_reg = '1;
    ctl_src[0] = LCC_SRC_LOCAL;
    cell_lut_mask = {10{16'haaaa}};
    cell_data = {rnd(), rnd()};
    e = lut_out();
    pulse();
    `CHK(cell_q, e)
    `CHK(cell_out_a, e)
    ctl_src[2] = LCC_SRC_LOCAL;
    ctl_idx[2] = 2'h1;
    cell_data = ~cell_data;
    pulse();
    `CHK(cell_q, e)
    local_ctl[1] = 1;
    pulse();
    `CHK(cell_q, ~e)
    cell_ff_type = {10{LCC_FF_T}};
    cell_lut_mask = '1;
    pulse();
    `CHK(cell_q, e)
    cell_ff_type = '0;
    cell_mode = {10{LCC_COUNTER}};
    cell_sync_en = '1;
    ctl_src[7] = LCC_SRC_LOCAL;
    ctl_src[6] = LCC_SRC_LOCAL;
    ctl_idx[7:6] = {2'h3, 2'h2};
    local_ctl[3:2] = 2'b11;
    cell_data = {rnd(), rnd()};
    pulse();
    `CHK(cell_q, 10'h000)
    local_ctl[2] = 0;
    for (int i = 0; i < 10; i++)
      e[i] = cell_data[i][2];
    pulse();
    `CHK(cell_q, e)
    $display("test register done");
    cell_aclr_func = {10{LCC_AC_PRESET}};
    cell_aclr_en = rnd();
    dev_reset_enable = 1;
    device_wide_reset_n = 0;
    tick();
    `CHK(cell_q, cell_aclr_en)
    // One more edge so the device reset assertion sees its antecedent
    tick();
    `CHK(cell_q, cell_aclr_en)
    $display("test device reset done");
    complete_run();
  end
endmodule
